/* pkg/fast_count_pkg.sv */
package fast_count_pkg;

	// counter geometry and feedback word layout
	localparam int COUNT_W = 25;
	localparam int WORD_W = 32;
	localparam int BIT_LIFE = 31;
	localparam int BIT_ISO = 30;
	localparam int BIT_PARAM = 29;
	localparam int BIT_EXT = 28;
	localparam int BIT_INPUT = 27;
	localparam int BIT_DIR = 26;
	localparam int BIT_GATE = 25;
	localparam logic [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};
	localparam logic [COUNT_W-1:0] COUNT_RESET = 25'h0000000;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;

	// input filter times and clock rate
	localparam int CLK_MHZ = 100;
	localparam int FILTER_SHORT_NS = 2500;
	localparam int FILTER_LONG_NS = 25000;
	localparam int FILTER_SHORT_CYC = (FILTER_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int FILTER_LONG_CYC = (FILTER_LONG_NS * CLK_MHZ + 999) / 1000;

	// track evaluation
	typedef enum logic [1:0] {
		EVAL_PULSE_DIR = 2'h0,
		EVAL_SINGLE = 2'h1,
		EVAL_DOUBLE = 2'h2,
		EVAL_QUAD = 2'h3
	} eval_e;

	// auxiliary input function
	typedef enum logic [1:0] {
		AUX_INPUT = 2'h0,
		AUX_HARDWARE_GATE = 2'h1,
		AUX_SYNC = 2'h2,
		AUX_BAD = 2'h3
	} aux_func_e;

	// run state, one-hot
	typedef enum logic [2:0] {
		RUN_UNCONF = 3'h1,
		RUN_ACTIVE = 3'h2,
		RUN_HELD = 3'h4
	} run_e;

	// parameter set handed over on each assignment
	typedef struct packed {
		logic stop_continue;
		eval_e eval_mode;
		logic filter_long_a;
		logic filter_long_b;
		logic filter_long_aux;
		logic dir_invert;
		logic gate_interrupt;
		logic gate_invert;
		aux_func_e auxiliary_input_function;
		logic iso_enable;
		logic signed [COUNT_W-1:0] load_value;
	} cfg_s;

	localparam cfg_s CFG_DEFAULT = '{
		stop_continue: 1'b0,
		eval_mode: EVAL_PULSE_DIR,
		filter_long_a: 1'b0,
		filter_long_b: 1'b0,
		filter_long_aux: 1'b0,
		dir_invert: 1'b0,
		gate_interrupt: 1'b0,
		gate_invert: 1'b0,
		auxiliary_input_function: AUX_INPUT,
		iso_enable: 1'b0,
		load_value: 25'h0000000
	};

	// pins as one carrier
	typedef struct packed {
		logic track_a;
		logic track_b;
		logic auxiliary_input;
		logic supply_short;
	} pins_s;

endpackage

/* rtl/input_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module input_filter
	import fast_count_pkg::*;
#(
	parameter int SHORT_CYC = FILTER_SHORT_CYC,
	parameter int LONG_CYC = FILTER_LONG_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// raw pin and selection
	input wire logic pin,
	input wire logic use_long,
	// filtered level
	output logic level
);

	initial begin
		if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC > 65535)
			$error("input_filter: bad filter counts");
	end

	typedef struct packed {
		logic [1:0] sync;
		logic [15:0] stable_cnt;
		logic level;
	} filt_s;

	filt_s st;
	filt_s next_st;
	logic [15:0] limit;

	// level changes only after the new value held for the filter time
	always_comb begin
		next_st = st;
		limit = use_long ? 16'(LONG_CYC) : 16'(SHORT_CYC);
		next_st.sync = {st.sync[0], pin};
		if (st.sync[1] == st.level) begin
			next_st.stable_cnt = 16'h0000;
		end else if (st.stable_cnt + 16'h0001 >= limit) begin
			next_st.level = st.sync[1];
			next_st.stable_cnt = 16'h0000;
		end else begin
			next_st.stable_cnt = st.stable_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;

endmodule // input_filter
`default_nettype wire

/* rtl/fast_mode_pulse_counter_feedback.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - sync edge loads counter with start value
// - sync acts only while gate counting active
// - every sync edge reloads, periodic
// - feedback word delivered as one unit
// - life bit inverts on every update
// - isochronous flag when configured and applied
// - parameter fault clears on correct assignment
// - external fault follows supply short
// - input flag mirrors auxiliary input level
// - direction flag one when counting down
// - gate flag shows counting active
// - inverted gate without gate function faults
// - filters selectable short or long
// - pulse-direction or x1/x2/x4 encoder decoding
// - direction track normal or inverted
// - controller stop halts or continues counting
// - counter wraps across 25 bits
// - gate opens rising, closes falling edge
// - no gate function: count after assignment
// - report values at sampling instant
module fast_mode_pulse_counter_feedback
	import fast_count_pkg::*;
#(
	parameter int SHORT_CYC = FILTER_SHORT_CYC,
	parameter int LONG_CYC = FILTER_LONG_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// encoder, auxiliary and supply pins
	input wire pins_s pins,
	// parameter assignment
	input wire cfg_s cfg_in,
	input wire logic cfg_load,
	// controller state and bus sampling instant
	input wire logic controller_stop,
	input wire logic iso_active,
	input wire logic sample_strobe,
	// feedback interface
	output logic [WORD_W-1:0] fast_mode_feedback_word,
	output logic feedback_update
);

	initial begin
		if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC)
			$error("fast_mode_pulse_counter_feedback: bad filter counts");
	end

	typedef struct packed {
		cfg_s cfg;
		run_e run;
		logic [COUNT_W-1:0] count;
		logic dir_down;
		logic hardware_gate;
		logic param_fault;
		logic prev_a;
		logic prev_b;
		logic prev_aux;
		logic [1:0] short_sync;
		logic [WORD_W-1:0] word;
		logic update;
	} state_s;

	state_s st;
	state_s next_st;
	logic lvl_a;
	logic lvl_b;
	logic lvl_aux;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;
	logic aux_rise;
	logic counting;
	logic step;
	logic step_up;
	logic sync_hit;
	logic cfg_fault;

	// debounced tracks and auxiliary input, filter time chosen per input
	input_filter #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) filt_a (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin(pins.track_a),
		.use_long(st.cfg.filter_long_a),
		.level(lvl_a)
	);
	input_filter #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) filt_b (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin(pins.track_b),
		.use_long(st.cfg.filter_long_b),
		.level(lvl_b)
	);
	input_filter #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) filt_aux (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin(pins.auxiliary_input),
		.use_long(st.cfg.filter_long_aux),
		.level(lvl_aux)
	);

	// auxiliary edges, gate polarity applied only in gate function
	always_comb begin
		aux_rise = lvl_aux & ~st.prev_aux;
		gate_lvl = lvl_aux ^ st.cfg.gate_invert;
		gate_rise = gate_lvl & ~(st.prev_aux ^ st.cfg.gate_invert);
		gate_fall = ~gate_lvl & (st.prev_aux ^ st.cfg.gate_invert);
	end

	// counting is live when assigned, not held, gate open, parameters sane
	assign counting = (st.run == RUN_ACTIVE) && st.hardware_gate && !st.param_fault;

	// track decoding: step request and its direction
	always_comb begin
		step = 1'b0;
		step_up = 1'b0;
		case (st.cfg.eval_mode)
			EVAL_PULSE_DIR: begin
				step = lvl_a & ~st.prev_a;
				step_up = ~lvl_b;
			end
			EVAL_SINGLE: begin
				step = (lvl_a ^ st.prev_a) & ~lvl_b & ~st.prev_b;
				step_up = lvl_a ^ st.prev_b;
			end
			EVAL_DOUBLE: begin
				step = (lvl_a ^ st.prev_a) & ~(lvl_b ^ st.prev_b);
				step_up = lvl_a ^ st.prev_b;
			end
			EVAL_QUAD: begin
				step = (lvl_a ^ st.prev_a) ^ (lvl_b ^ st.prev_b);
				step_up = lvl_a ^ st.prev_b;
			end
			default: begin
				step = 1'b0;
				step_up = 1'b0;
			end
		endcase
		step_up = step_up ^ st.cfg.dir_invert;
	end

	// reference edge honoured only with counting active
	assign sync_hit = (st.cfg.auxiliary_input_function == AUX_SYNC) && aux_rise && counting;

	// inverted gate without gate function, or unknown function, is a fault
	assign cfg_fault = (cfg_in.gate_invert && cfg_in.auxiliary_input_function != AUX_HARDWARE_GATE)
		|| cfg_in.auxiliary_input_function == AUX_BAD;

	// next-state logic
	always_comb begin
		next_st = st;
		next_st.prev_a = lvl_a;
		next_st.prev_b = lvl_b;
		next_st.prev_aux = lvl_aux;
		next_st.short_sync = {st.short_sync[0], pins.supply_short};
		next_st.update = 1'b0;

		// run state follows assignment and controller stop
		case (st.run)
			RUN_UNCONF: begin
				next_st.run = RUN_UNCONF;
			end
			RUN_ACTIVE: begin
				if (controller_stop && !st.cfg.stop_continue)
					next_st.run = RUN_HELD;
			end
			RUN_HELD: begin
				if (!controller_stop || st.cfg.stop_continue)
					next_st.run = RUN_ACTIVE;
			end
			default: begin
				next_st.run = RUN_UNCONF;
			end
		endcase

		// counting with wrap, sync reload wins over a step
		if (sync_hit) begin
			next_st.count = st.cfg.load_value;
		end else if (counting && step) begin
			next_st.count = step_up ? st.count + 25'h0000001 : st.count - 25'h0000001;
			next_st.dir_down = ~step_up;
		end

		// hardware gate edges; cancel reloads, interrupt resumes
		if (st.cfg.auxiliary_input_function == AUX_HARDWARE_GATE) begin
			if (gate_rise) begin
				next_st.hardware_gate = 1'b1;
				if (!st.cfg.gate_interrupt)
					next_st.count = st.cfg.load_value;
			end else if (gate_fall) begin
				next_st.hardware_gate = 1'b0;
			end
		end

		// assignment: load start value, fault flag re-evaluated
		if (cfg_load) begin
			next_st.cfg = cfg_in;
			next_st.count = cfg_in.load_value;
			next_st.param_fault = cfg_fault;
			next_st.run = (controller_stop && !cfg_in.stop_continue) ? RUN_HELD : RUN_ACTIVE;
			if (cfg_in.auxiliary_input_function == AUX_HARDWARE_GATE)
				next_st.hardware_gate = lvl_aux ^ cfg_in.gate_invert;
			else
				next_st.hardware_gate = 1'b1;
		end

		// capture the whole word at the sampling instant
		if (sample_strobe) begin
			next_st.word[BIT_LIFE] = ~st.word[BIT_LIFE];
			next_st.word[BIT_ISO] = st.cfg.iso_enable & iso_active & (st.run != RUN_UNCONF);
			next_st.word[BIT_PARAM] = st.param_fault;
			next_st.word[BIT_EXT] = st.short_sync[1];
			next_st.word[BIT_INPUT] = lvl_aux;
			next_st.word[BIT_DIR] = st.dir_down;
			next_st.word[BIT_GATE] = counting;
			next_st.word[COUNT_W-1:0] = st.count;
			next_st.update = 1'b1;
		end
	end

	// one register for all state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st.cfg <= CFG_DEFAULT;
			st.run <= RUN_UNCONF;
			st.count <= COUNT_RESET;
			st.dir_down <= 1'b0;
			st.hardware_gate <= 1'b0;
			st.param_fault <= 1'b0;
			st.prev_a <= 1'b0;
			st.prev_b <= 1'b0;
			st.prev_aux <= 1'b0;
			st.short_sync <= 2'h0;
			st.word <= WORD_RESET;
			st.update <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// word only changes at the sampling instant
	assign fast_mode_feedback_word = st.word;
	assign feedback_update = st.update;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// helper: last assigned load value
	logic [COUNT_W-1:0] load_seen;
	assign load_seen = st.cfg.load_value;

	a_life_toggle: assert property (sample_strobe |=>
		fast_mode_feedback_word[BIT_LIFE] != $past(fast_mode_feedback_word[BIT_LIFE]))
		else $error("life bit did not toggle");

	a_word_frozen: assert property (!sample_strobe |=> $stable(fast_mode_feedback_word))
		else $error("feedback word changed outside sampling");

	a_sync_reload: assert property (sync_hit && !cfg_load |=> st.count == load_seen)
		else $error("sync edge did not load start value");

	a_sync_gated: assert property ((st.cfg.auxiliary_input_function == AUX_SYNC) && !counting
		&& !cfg_load |=> st.count == $past(st.count))
		else $error("counter moved without active counting");

	a_wrap_up: assert property (counting && step && step_up && st.count == COUNT_MAX
		&& !sync_hit && !cfg_load |=> st.count == COUNT_RESET)
		else $error("up wrap failed");

	a_wrap_down: assert property (counting && step && !step_up && st.count == COUNT_RESET
		&& !sync_hit && !cfg_load |=> st.count == COUNT_MAX)
		else $error("down wrap failed");

	a_param_error: assert property (cfg_load && cfg_in.gate_invert
		&& cfg_in.auxiliary_input_function != AUX_HARDWARE_GATE |=> st.param_fault ##1 !counting)
		else $error("inverted gate without gate function not flagged");

	a_gate_edges: assert property ((st.cfg.auxiliary_input_function == AUX_HARDWARE_GATE) && !cfg_load
		&& gate_fall |=> !st.hardware_gate)
		else $error("gate did not close on falling edge");

	a_ext_follow: assert property (sample_strobe ##1 1'b1 |->
		fast_mode_feedback_word[BIT_EXT] == $past(st.short_sync[1]))
		else $error("external fault flag wrong");

	a_dir_report: assert property (sample_strobe && st.dir_down
		|=> fast_mode_feedback_word[BIT_DIR])
		else $error("down direction not reported");

	a_no_gate_run: assert property (cfg_load && cfg_in.auxiliary_input_function == AUX_INPUT
		&& !cfg_in.gate_invert && !controller_stop |=> counting)
		else $error("counting not active after assignment");

	// stop, gate, fault, feedback flag and decoding checks
	a_dir_latch: assert property (counting && step && !sync_hit && !cfg_load
		|=> st.dir_down == !$past(step_up))
		else $error("direction not latched on step");

	a_stop_hold: assert property ((st.run == RUN_ACTIVE) && controller_stop && !st.cfg.stop_continue
		&& !cfg_load |=> !counting)
		else $error("counting went on after controller stop");

	a_held_resume: assert property ((st.run == RUN_HELD) && !controller_stop && !cfg_load
		|=> st.run == RUN_ACTIVE)
		else $error("counting did not resume after stop");

	a_gate_open: assert property ((st.cfg.auxiliary_input_function == AUX_HARDWARE_GATE) && !cfg_load
		&& gate_rise |=> st.hardware_gate)
		else $error("gate did not open on rising edge");

	a_cancel_reload: assert property ((st.cfg.auxiliary_input_function == AUX_HARDWARE_GATE) && gate_rise
		&& !st.cfg.gate_interrupt && !cfg_load |=> st.count == load_seen)
		else $error("canceling gate did not restart from load value");

	a_fault_clear: assert property (cfg_load && !cfg_in.gate_invert
		&& cfg_in.auxiliary_input_function != AUX_BAD |=> !st.param_fault)
		else $error("parameter fault kept after correct assignment");

	a_iso_flag: assert property (sample_strobe && !iso_active |=> !fast_mode_feedback_word[BIT_ISO])
		else $error("isochronous flag set without isochronous operation");

	a_update_pulse: assert property (sample_strobe |=> feedback_update)
		else $error("no update pulse after sampling");

	a_input_mirror: assert property (sample_strobe ##1 1'b1 |->
		fast_mode_feedback_word[BIT_INPUT] == $past(lvl_aux))
		else $error("input level flag wrong");

	a_quad_up: assert property ((st.cfg.eval_mode == EVAL_QUAD) && counting && !st.cfg.dir_invert
		&& lvl_a && !st.prev_a && !lvl_b && !st.prev_b && !sync_hit && !cfg_load && !gate_rise
		|=> st.count == $past(st.count) + 25'h0000001)
		else $error("quadrature up step not counted");

	// main scenarios
	c_sync_load: cover property (sync_hit ##1 sample_strobe);
	c_gate_cycle: cover property (gate_rise ##[1:50] gate_fall);
	c_wrap: cover property (counting && step && st.count == COUNT_MAX);
	c_stop_hold: cover property (st.run == RUN_HELD && aux_rise);
	c_cancel: cover property (gate_rise && !st.cfg.gate_interrupt && st.cfg.auxiliary_input_function == AUX_HARDWARE_GATE);

endmodule // fast_mode_pulse_counter_feedback
`default_nettype wire

/* verification/encoder_source.sv */
`timescale 1ns/1ps
`default_nettype none
module encoder_source (
	// clock
	input wire logic clk_sys,
	// tracks
	output logic track_a,
	output logic track_b
);
	// idle: both tracks low
	initial begin
		track_a = 1'b0;
		track_b = 1'b0;
	end

	// pulse and direction, every phase well beyond the filter time
	task automatic pulses(input logic down, input int n);
		@(posedge clk_sys);
		#1 track_b = down;
		repeat (12) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			#1 track_a = 1'b1;
			repeat (12) @(posedge clk_sys);
			#1 track_a = 1'b0;
			repeat (12) @(posedge clk_sys);
		end
	endtask

	// quadrature cycles from 00, track a leads when counting up
	task automatic quad(input logic down, input int n);
		for (int i = 0; i < 4 * n; i++) begin
			@(posedge clk_sys);
			#1;
			if ((i % 2 == 0) != down)
				track_a = ~track_a;
			else
				track_b = ~track_b;
			repeat (11) @(posedge clk_sys);
		end
	endtask

	// one short pulse on the count track, w cycles wide
	task automatic glitch(input int w);
		@(posedge clk_sys);
		#1 track_a = 1'b1;
		repeat (w) @(posedge clk_sys);
		#1 track_a = 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask
endmodule // encoder_source
`default_nettype wire

/* verification/test_fast_mode_pulse_counter_feedback.sv */
`timescale 1ns/1ps
`default_nettype none
module test_fast_mode_pulse_counter_feedback
	import fast_count_pkg::*;
;
	localparam logic [WORD_W-1:0] M_CNT = 32'h01ffffff;
	localparam logic [WORD_W-1:0] M_GATE = 32'h1 << BIT_GATE;
	localparam logic [WORD_W-1:0] M_DIR = 32'h1 << BIT_DIR;
	localparam logic [WORD_W-1:0] M_IN = 32'h1 << BIT_INPUT;
	localparam logic [WORD_W-1:0] M_EXT = 32'h1 << BIT_EXT;
	localparam logic [WORD_W-1:0] M_PAR = 32'h1 << BIT_PARAM;
	localparam logic [WORD_W-1:0] M_ISO = 32'h1 << BIT_ISO;

	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic aux_pin = 1'b0;
	logic short_pin = 1'b0;
	logic cfg_load = 1'b0;
	logic iso_active = 1'b0;
	logic sample_strobe = 1'b0;
	logic ctrl_stop = 1'b0;
	logic enc_a;
	logic enc_b;
	cfg_s cfg_in = CFG_DEFAULT;
	cfg_s c;
	pins_s pins;
	logic [WORD_W-1:0] word;
	logic upd;
	logic life = 1'b0;
	int errors = 0;
	int compares = 0;
	int cycles = 0;

	// clock
	always #5 clk_sys = ~clk_sys;

	assign pins = '{track_a: enc_a, track_b: enc_b, auxiliary_input: aux_pin, supply_short: short_pin};

	// short filters so that edges settle within a few cycles
	fast_mode_pulse_counter_feedback #(.SHORT_CYC(2), .LONG_CYC(4)) u_dut (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pins(pins),
		.cfg_in(cfg_in),
		.cfg_load(cfg_load),
		.controller_stop(ctrl_stop),
		.iso_active(iso_active),
		.sample_strobe(sample_strobe),
		.fast_mode_feedback_word(word),
		.feedback_update(upd)
	);

	encoder_source u_enc (
		.clk_sys(clk_sys),
		.track_a(enc_a),
		.track_b(enc_b)
	);

	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus sampling instant, answer looked at one cycle later
	task automatic sample(input logic [WORD_W-1:0] mask, input logic [WORD_W-1:0] exp);
		@(posedge clk_sys);
		#1 sample_strobe = 1'b1;
		@(posedge clk_sys);
		#1 sample_strobe = 1'b0;
		life = ~life;
		check({31'h0, upd}, 32'h1);
		check({31'h0, word[BIT_LIFE]}, {31'h0, life});
		check(word & mask, exp);
	endtask

	task automatic apply_cfg(input cfg_s v);
		@(posedge clk_sys);
		#1 cfg_in = v;
		cfg_load = 1'b1;
		@(posedge clk_sys);
		#1 cfg_load = 1'b0;
	endtask

	task automatic set_aux(input logic v);
		@(posedge clk_sys);
		#1 aux_pin = v;
		repeat (12) @(posedge clk_sys);
	endtask

	task automatic t_assign();
		c = CFG_DEFAULT;
		c.iso_enable = 1'b1;
		c.load_value = 25'h0000005;
		iso_active = 1'b1;
		apply_cfg(c);
		sample(M_CNT | M_GATE | M_ISO | M_PAR, 32'h5 | M_GATE | M_ISO);
		iso_active = 1'b0;
		sample(M_ISO, 32'h0);
		$display("test assign done");
	endtask

	task automatic t_count();
		c = CFG_DEFAULT;
		c.load_value = 25'h0000005;
		apply_cfg(c);
		u_enc.pulses(1'b0, 3);
		sample(M_CNT | M_DIR, 32'h8);
		u_enc.pulses(1'b1, 2);
		sample(M_CNT | M_DIR, 32'h6 | M_DIR);
		c.load_value = COUNT_MAX;
		apply_cfg(c);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_DIR, 32'h0);
		u_enc.pulses(1'b1, 1);
		sample(M_CNT | M_DIR, {7'h0, COUNT_MAX} | M_DIR);
		c.load_value = 25'h0000005;
		c.dir_invert = 1'b1;
		apply_cfg(c);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_DIR, 32'h4 | M_DIR);
		$display("test count done");
	endtask

	task automatic t_fault();
		c = CFG_DEFAULT;
		c.gate_invert = 1'b1;
		apply_cfg(c);
		sample(M_PAR | M_GATE, M_PAR);
		c.gate_invert = 1'b0;
		apply_cfg(c);
		sample(M_PAR | M_GATE, M_GATE);
		short_pin = 1'b1;
		repeat (4) @(posedge clk_sys);
		sample(M_EXT, M_EXT);
		short_pin = 1'b0;
		repeat (4) @(posedge clk_sys);
		sample(M_EXT, 32'h0);
		$display("test fault done");
	endtask

	task automatic t_gate();
		c = CFG_DEFAULT;
		c.auxiliary_input_function = AUX_HARDWARE_GATE;
		c.gate_interrupt = 1'b1;
		c.load_value = 25'h0000003;
		apply_cfg(c);
		u_enc.pulses(1'b0, 2);
		sample(M_CNT | M_GATE | M_IN, 32'h3);
		set_aux(1'b1);
		u_enc.pulses(1'b0, 2);
		sample(M_CNT | M_GATE | M_IN, 32'h5 | M_GATE | M_IN);
		set_aux(1'b0);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_GATE, 32'h5);
		set_aux(1'b1);
		sample(M_CNT | M_GATE, 32'h5 | M_GATE);
		set_aux(1'b0);
		c.gate_interrupt = 1'b0;
		c.gate_invert = 1'b1;
		apply_cfg(c);
		u_enc.pulses(1'b0, 2);
		set_aux(1'b1);
		set_aux(1'b0);
		sample(M_CNT | M_GATE | M_PAR, 32'h3 | M_GATE);
		$display("test gate done");
	endtask

	task automatic t_sync();
		c = CFG_DEFAULT;
		c.auxiliary_input_function = AUX_SYNC;
		c.load_value = 25'h0000010;
		apply_cfg(c);
		u_enc.pulses(1'b0, 3);
		sample(M_CNT, 32'h13);
		set_aux(1'b1);
		sample(M_CNT | M_IN, 32'h10 | M_IN);
		set_aux(1'b0);
		u_enc.pulses(1'b0, 2);
		sample(M_CNT | M_IN, 32'h12);
		set_aux(1'b1);
		sample(M_CNT, 32'h10);
		$display("test sync done");
	endtask

	task automatic t_stop();
		c = CFG_DEFAULT;
		c.load_value = 25'h0000020;
		apply_cfg(c);
		ctrl_stop = 1'b1;
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_GATE, 32'h20);
		c.stop_continue = 1'b1;
		apply_cfg(c);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_GATE, 32'h21 | M_GATE);
		ctrl_stop = 1'b0;
		c = CFG_DEFAULT;
		c.auxiliary_input_function = AUX_SYNC;
		c.load_value = 25'h0000010;
		apply_cfg(c);
		u_enc.pulses(1'b0, 2);
		#1 ctrl_stop = 1'b1;
		set_aux(1'b0);
		set_aux(1'b1);
		sample(M_CNT | M_GATE | M_IN, 32'h12 | M_IN);
		ctrl_stop = 1'b0;
		$display("test stop done");
	endtask

	task automatic t_quad();
		c = CFG_DEFAULT;
		c.eval_mode = EVAL_QUAD;
		c.load_value = 25'h0000100;
		apply_cfg(c);
		u_enc.quad(1'b0, 2);
		sample(M_CNT | M_DIR, 32'h108);
		u_enc.quad(1'b1, 1);
		sample(M_CNT | M_DIR, 32'h104 | M_DIR);
		c.eval_mode = EVAL_DOUBLE;
		apply_cfg(c);
		u_enc.quad(1'b0, 1);
		sample(M_CNT | M_DIR, 32'h102);
		c.eval_mode = EVAL_SINGLE;
		apply_cfg(c);
		u_enc.quad(1'b1, 1);
		sample(M_CNT | M_DIR, 32'h0ff | M_DIR);
		$display("test quad done");
	endtask

	task automatic t_filter();
		c = CFG_DEFAULT;
		c.load_value = 25'h0000040;
		apply_cfg(c);
		u_enc.glitch(3);
		sample(M_CNT, 32'h41);
		c.filter_long_a = 1'b1;
		apply_cfg(c);
		u_enc.glitch(3);
		sample(M_CNT, 32'h40);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT, 32'h41);
		$display("test filter done");
	endtask

	task automatic t_reset();
		@(posedge clk_sys);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		life = 1'b0;
		check(word, WORD_RESET);
		check({31'h0, upd}, 32'h0);
		u_enc.pulses(1'b0, 1);
		sample(M_CNT | M_GATE, 32'h0);
		$display("test reset done");
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		check(word, WORD_RESET);
		t_assign();
		t_count();
		t_fault();
		t_gate();
		t_sync();
		t_stop();
		t_quad();
		t_filter();
		t_reset();
		print_verdict();
	end
endmodule // test_fast_mode_pulse_counter_feedback
`default_nettype wire
